// >>> hdl/icw_regs.svh
// constants of the instruction clock watchdog
`ifndef ICW_REGS_SVH
`define ICW_REGS_SVH
`define ICW_CNT_WIDTH    16
`define ICW_CNT_INIT     16'hFFFF
`define ICW_CNT_ZERO     16'h0000
`define ICW_ENABLE_RESET 1'b1
`define ICW_FLAG_RESET   1'b0
`define ICW_PIN_IDLE     1'b1
`define ICW_ARMED_RESET  1'b0
`endif

// >>> hdl/icw_pkg.sv
// types of the instruction clock watchdog
package icw_pkg;
    typedef logic [15:0] icw_count_t;
    typedef enum logic [1:0] {
        ICW_CNT_HOLD,
        ICW_CNT_DEC,
        ICW_CNT_RELOAD,
        ICW_CNT_LOAD
    } icw_cnt_action_t;
endpackage

// >>> hdl/icw_watchdog.sv
// instruction clock watchdog: guard counter, underflow flags, enable flag, reset drive
//
// Summary of operation
// RULE_01: after reset load guard counter with all ones, decrement per instruction clock.
// RULE_02: a count pulse at zero is an underflow and sets the first flag.
// RULE_03: underflow with first flag still set sets second flag, drives reset low.
// RULE_04: software must restart at least every 65534 machine cycles.
// RULE_05: reset function active while enable flag is one; flag is one after reset.
// RULE_06: enable flag clears only when disable op is directly followed by restart op.
// RULE_07: enable flag set on every system reset and every back-up entry.
// RULE_08: restart with first flag set clears it and skips next; otherwise no skip.
// RULE_09: restart skip works even while the reset function is disabled.
// RULE_10: a disable op not directly followed by restart leaves the watchdog running.
// RULE_11: back-up entry reinitialises the first flag and the guard counter.
// RULE_12: software re-disables after each return from back-up if unwanted.
// RULE_13: software clears the first flag with restart just before back-up.
// RULE_14: while disabled, counting and first flag go on; no second flag, no reset.
`timescale 1ns/100ps
`include "icw_regs.svh"

module icw_watchdog #(
    parameter logic [`ICW_CNT_WIDTH-1:0] INIT_COUNT = `ICW_CNT_INIT
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic inst_clk_en_i,
    input  wire logic instr_exec_i,
    input  wire logic guard_restart_op_i,
    input  wire logic guard_disable_op_i,
    input  wire logic backup_entry_i,
    output logic      skip_next_o,
    output logic      reset_n_o,
    output logic      guard_enable_flag_o,
    output logic      first_underflow_flag_o,
    output logic      second_underflow_flag_o
);

    // ******************************
    // state
    // ******************************
    icw_pkg::icw_count_t      guard_counter_reg;
    icw_pkg::icw_count_t      counter_next;
    logic                     guard_enable_flag_reg;
    logic                     first_underflow_flag_reg;
    logic                     second_underflow_flag_reg;
    logic                     reset_n_reg;
    logic                     disable_armed_reg;
    logic                     skip_reg;
    icw_pkg::icw_cnt_action_t cnt_action_w;

    // ******************************
    // helpers
    // ******************************
    // an op only counts in the cycle the core reports it as executed
    function automatic logic op_taken(
        input logic exec,
        input logic op
    );
        op_taken = exec & op;
    endfunction

    // set wins over clear, so an event is never lost against a service
    function automatic logic sticky_next(
        input logic cur,
        input logic set,
        input logic clr
    );
        sticky_next = set | (cur & ~clr);
    endfunction

    // back-up entry outranks a count pulse in the same cycle
    function automatic icw_pkg::icw_cnt_action_t pick_action(
        input logic backup,
        input logic uflow,
        input logic tick
    );
        if (backup) begin
            pick_action = icw_pkg::ICW_CNT_LOAD;
        end else if (uflow) begin
            pick_action = icw_pkg::ICW_CNT_RELOAD;
        end else if (tick) begin
            pick_action = icw_pkg::ICW_CNT_DEC;
        end else begin
            pick_action = icw_pkg::ICW_CNT_HOLD;
        end
    endfunction

    // ******************************
    // decode
    // ******************************
    wire logic restart_w    = op_taken(instr_exec_i, guard_restart_op_i);
    wire logic disable_w    = op_taken(instr_exec_i, guard_disable_op_i);
    wire logic at_zero_w    = (guard_counter_reg == `ICW_CNT_ZERO);
    wire logic underflow_w  = inst_clk_en_i & at_zero_w; // RULE_02
    // a restart in the same cycle as the underflow counts as serviced
    wire logic unserviced_w = underflow_w & first_underflow_flag_reg & ~restart_w;
    wire logic second_w     = unserviced_w & guard_enable_flag_reg; // RULE_03 RULE_14
    wire logic turn_off_w   = restart_w & disable_armed_reg; // RULE_06 RULE_10
    wire logic skip_w       = restart_w & first_underflow_flag_reg; // RULE_08 RULE_09
    // any executed instruction ends the "directly followed" window
    wire logic armed_next   = instr_exec_i ? disable_w : disable_armed_reg; // RULE_10
    wire logic first_keep_w = sticky_next(first_underflow_flag_reg, underflow_w, restart_w); // RULE_08
    wire logic first_next   = ~backup_entry_i & first_keep_w; // RULE_11
    wire logic enable_next  = sticky_next(guard_enable_flag_reg, backup_entry_i, turn_off_w); // RULE_07 RULE_06
    // sticky until system reset; the reset pin pulls the core and us back
    wire logic second_next  = sticky_next(second_underflow_flag_reg, second_w, 1'b0); // RULE_03

    // ******************************
    // counter step
    // ******************************
    assign cnt_action_w = pick_action(backup_entry_i, underflow_w, inst_clk_en_i);

    always_comb begin
        counter_next = guard_counter_reg;
        unique case (cnt_action_w)
            icw_pkg::ICW_CNT_LOAD: begin
                counter_next = INIT_COUNT; // RULE_11
            end
            icw_pkg::ICW_CNT_RELOAD: begin
                counter_next = INIT_COUNT;
            end
            icw_pkg::ICW_CNT_DEC: begin
                counter_next = guard_counter_reg - 16'h0001; // RULE_01
            end
            icw_pkg::ICW_CNT_HOLD: begin
                counter_next = guard_counter_reg;
            end
        endcase
    end

    // ******************************
    // registers
    // ******************************
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            guard_counter_reg <= INIT_COUNT; // RULE_01
        end else begin
            guard_counter_reg <= counter_next;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            guard_enable_flag_reg <= `ICW_ENABLE_RESET; // RULE_05 RULE_07
        end else begin
            guard_enable_flag_reg <= enable_next;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_underflow_flag_reg <= `ICW_FLAG_RESET;
        end else begin
            first_underflow_flag_reg <= first_next;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            second_underflow_flag_reg <= `ICW_FLAG_RESET;
        end else begin
            second_underflow_flag_reg <= second_next;
        end
    end

    // own flop for the pin so the output is never a gate after the flag
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_n_reg <= `ICW_PIN_IDLE;
        end else begin
            reset_n_reg <= ~second_next; // RULE_03
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            disable_armed_reg <= `ICW_ARMED_RESET;
        end else begin
            disable_armed_reg <= armed_next;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            skip_reg <= 1'b0;
        end else begin
            skip_reg <= skip_w;
        end
    end

    // ******************************
    // outputs
    // ******************************
    assign skip_next_o             = skip_reg;
    assign reset_n_o               = reset_n_reg; // RULE_03
    assign guard_enable_flag_o     = guard_enable_flag_reg;
    assign first_underflow_flag_o  = first_underflow_flag_reg;
    assign second_underflow_flag_o = second_underflow_flag_reg;

endmodule

// >>> bench/icw_watchdog_sva.sv
// assertions on the instruction clock watchdog ports
`timescale 1ns/100ps
module icw_watchdog_sva (
    input wire logic ref_clk_i, rst_n_i, inst_clk_en_i, instr_exec_i, guard_restart_op_i,
    input wire logic guard_disable_op_i, backup_entry_i, skip_next_o, reset_n_o,
    input wire logic guard_enable_flag_o, first_underflow_flag_o, second_underflow_flag_o
);
    wire rs = instr_exec_i && guard_restart_op_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_PIN: assert property (reset_n_o == !second_underflow_flag_o) else $error("pin");
    AST_F2_HOLD: assert property (second_underflow_flag_o |=> second_underflow_flag_o) else $error("f2");
    AST_SKIP: assert property (rs && first_underflow_flag_o |=> skip_next_o) else $error("skip");
    AST_NOSKIP: assert property (rs && !first_underflow_flag_o |=> !skip_next_o) else $error("noskip");
    AST_EN: assert property ($fell(guard_enable_flag_o) |-> $past(rs)) else $error("en");
    AST_BK: assert property (backup_entry_i |=> guard_enable_flag_o && !first_underflow_flag_o) else $error("bk");
    AST_DIS: assert property (!guard_enable_flag_o && !second_underflow_flag_o |=> !second_underflow_flag_o) else $error("dis");
    AST_F1: assert property ($rose(first_underflow_flag_o) |-> $past(inst_clk_en_i)) else $error("f1");
    cover property (skip_next_o);
    cover property (!reset_n_o);
    cover property ($fell(guard_enable_flag_o));
endmodule
bind icw_watchdog icw_watchdog_sva u_sva (.*);

// >>> bench/icw_core_model.sv
// core model issuing watchdog instructions
`timescale 1ns/100ps
module icw_core_model (
    input  wire logic clk_i,
    output logic      exec_o, rst_op_o, dis_op_o
);
    initial {exec_o, rst_op_o, dis_op_o} = 3'h0;
    // one instruction per call; a gap cycle follows, which order still allows
    task op(input logic r, input logic d);
        @(negedge clk_i) {exec_o, rst_op_o, dis_op_o} = {1'h1, r, d};
        @(negedge clk_i) {exec_o, rst_op_o, dis_op_o} = 3'h0;
    endtask
endmodule

// >>> bench/icw_watchdog_tb_top.sv
// self-checking bench for the instruction clock watchdog
`timescale 1ns/100ps
module icw_watchdog_tb_top;
    logic ref_clk_i = 1'h0, rst_n_i = 1'h0, cnt = 1'h0, bk = 1'h0;
    logic ex, ro, dop, sk, rn, en, f1, f2;
    int err_total = 0, tests_run = 0, seed = 65638;
    localparam logic [15:0] INIT = 16'h0003; // short count keeps the run small
    always #4 ref_clk_i = ~ref_clk_i;
    icw_watchdog #(.INIT_COUNT(INIT)) u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .inst_clk_en_i(cnt),
        .instr_exec_i(ex), .guard_restart_op_i(ro), .guard_disable_op_i(dop), .backup_entry_i(bk),
        .skip_next_o(sk), .reset_n_o(rn), .guard_enable_flag_o(en), .first_underflow_flag_o(f1),
        .second_underflow_flag_o(f2));
    icw_core_model u_core (.clk_i(ref_clk_i), .exec_o(ex), .rst_op_o(ro), .dis_op_o(dop));
    function int uf(); return int'(INIT) + 1; endfunction
    task chk(input string s, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin err_total++; $display("BAD %s exp %b got %b", s, e, g); end
    endtask
    task pulse(input int n);
        repeat (n) begin
            repeat ($random(seed) & 1) @(negedge ref_clk_i);
            @(negedge ref_clk_i) cnt = 1'h1;
            @(negedge ref_clk_i) cnt = 1'h0;
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge ref_clk_i);
        rst_n_i = 1'h1;
        chk("en", 1'h1, en);
        pulse(uf() - 1); chk("f1", 1'h0, f1);
        pulse(1); chk("f1", 1'h1, f1);
        u_core.op(1'h1, 1'h0); chk("skip", 1'h1, sk);
        u_core.op(1'h1, 1'h0); chk("skip", 1'h0, sk);
        u_core.op(1'h0, 1'h1); u_core.op(1'h0, 1'h0); u_core.op(1'h1, 1'h0); chk("en", 1'h1, en);
        u_core.op(1'h0, 1'h1); u_core.op(1'h1, 1'h0); chk("en", 1'h0, en);
        pulse(2 * uf()); chk("f2", 1'h0, f2);
        u_core.op(1'h1, 1'h0); chk("skip", 1'h1, sk);
        pulse(uf());
        @(negedge ref_clk_i) bk = 1'h1;
        @(negedge ref_clk_i) bk = 1'h0;
        chk("en", 1'h1, en);
        chk("f1", 1'h0, f1);
        pulse(2 * uf()); chk("rst", 1'h0, rn);
        @(negedge ref_clk_i) rst_n_i = 1'h0;
        @(negedge ref_clk_i) rst_n_i = 1'h1;
        chk("rst", 1'h1, rn);
        chk("en", 1'h1, en);
        pulse(uf()); chk("f1", 1'h1, f1);
        report_and_stop;
    end
endmodule
